// ==== fpss_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpss_core
  import fpss_pkg::*;
#(
  parameter bit OVERTEMP_EN = 1'b1,
  parameter bit SENSE_EN    = 1'b1
) (
  // Clock and reset.
  input  wire logic      sys_clk_in,
  input  wire logic      nrst_in,
  // Comparator results and ramp period tick from the analog side.
  input  wire fpss_cmp_t cmp_in,
  input  wire logic      ramp_tick_in,
  // Fan current pulse input.
  input  wire logic      fan_pulse_in,
  // Fan drive output.
  output logic           fan_drive_out,
  // Open-drain flag pin, enable high while pulling low.
  output logic           overtemp_flag_n_out,
  output logic           overtemp_flag_n_oe_out
);

  // Refuses counts that the cycle counter cannot reach.
  if (STARTUP_CYCLES >= (1 << CNT_W) || RECOVER_WINDOW >= (1 << CNT_W) || MISSING_CYCLES >= (1 << CNT_W) ||
      RECOVER_PULSES >= (1 << CNT_W) || DIAG_CYCLES >= (1 << CNT_W)) begin : g_cnt_chk
    $error("fpss_core: counter width too small");
  end

  function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input int lim);
    cnt_hit = (cnt == CNT_W'(lim - 1));
  endfunction : cnt_hit

  // Synchronisers: three stages for each asynchronous comparator and the pulse input.
  logic [2:0] pulse_sync_q, pulse_sync_d;
  logic [2:0] tick_sync_q,  tick_sync_d;
  logic [2:0] duty_sync_q,  duty_sync_d;
  logic [2:0] shdn_sync_q,  shdn_sync_d;
  logic [2:0] aoff_sync_q,  aoff_sync_d;
  logic [2:0] otmp_sync_q,  otmp_sync_d;
  logic       pulse_lvl_q,  pulse_lvl_d;
  logic       tick_lvl_q,   tick_lvl_d;
  logic       duty_lvl_q,   duty_lvl_d;
  logic       shdn_lvl_q,   shdn_lvl_d;
  logic       aoff_lvl_q,   aoff_lvl_d;
  logic       otmp_lvl_q,   otmp_lvl_d;

  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction : filt

  always_comb begin
    pulse_sync_d = {pulse_sync_q[1:0], fan_pulse_in};
    tick_sync_d  = {tick_sync_q[1:0], ramp_tick_in};
    duty_sync_d  = {duty_sync_q[1:0], cmp_in.duty_hi};
    shdn_sync_d  = {shdn_sync_q[1:0], cmp_in.shutdown};
    aoff_sync_d  = {aoff_sync_q[1:0], cmp_in.auto_off};
    otmp_sync_d  = {otmp_sync_q[1:0], cmp_in.overtemp};
    pulse_lvl_d  = filt(pulse_sync_q, pulse_lvl_q);
    tick_lvl_d   = filt(tick_sync_q, tick_lvl_q);
    duty_lvl_d   = filt(duty_sync_q, duty_lvl_q);
    shdn_lvl_d   = filt(shdn_sync_q, shdn_lvl_q);
    aoff_lvl_d   = filt(aoff_sync_q, aoff_lvl_q);
    otmp_lvl_d   = filt(otmp_sync_q, otmp_lvl_q);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pulse_sync_q <= 3'h0;
      tick_sync_q  <= 3'h0;
      duty_sync_q  <= 3'h0;
      shdn_sync_q  <= 3'h0;
      aoff_sync_q  <= 3'h0;
      otmp_sync_q  <= 3'h0;
      pulse_lvl_q  <= 1'b0;
      tick_lvl_q   <= 1'b0;
      duty_lvl_q   <= 1'b0;
      shdn_lvl_q   <= 1'b0;
      aoff_lvl_q   <= 1'b0;
      otmp_lvl_q   <= 1'b0;
    end else begin
      pulse_sync_q <= pulse_sync_d;
      tick_sync_q  <= tick_sync_d;
      duty_sync_q  <= duty_sync_d;
      shdn_sync_q  <= shdn_sync_d;
      aoff_sync_q  <= aoff_sync_d;
      otmp_sync_q  <= otmp_sync_d;
      pulse_lvl_q  <= pulse_lvl_d;
      tick_lvl_q   <= tick_lvl_d;
      duty_lvl_q   <= duty_lvl_d;
      shdn_lvl_q   <= shdn_lvl_d;
      aoff_lvl_q   <= aoff_lvl_d;
      otmp_lvl_q   <= otmp_lvl_d;
    end
  end

  // One-cycle events from rising edges of the filtered levels.
  logic pulse_ev;
  logic tick_ev;
  assign pulse_ev = SENSE_EN && pulse_lvl_d && !pulse_lvl_q;
  assign tick_ev  = tick_lvl_d && !tick_lvl_q;

  // Sequencer state.
  fpss_state_t      state_q,  state_d;
  logic [CNT_W-1:0] cyc_q,    cyc_d;
  logic [CNT_W-1:0] pcnt_q,   pcnt_d;
  logic             seen_q,   seen_d;
  logic             drive_q,  drive_d;
  logic             flag_q,   flag_d;

  always_comb begin
    state_d = state_q;
    cyc_d   = cyc_q;
    pcnt_d  = pcnt_q;
    seen_d  = seen_q || pulse_ev;
    if (shdn_lvl_q) begin
      state_d = FPSS_SHUTDOWN;
      cyc_d   = CNT_ZERO;
      seen_d  = 1'b0;
    end else if (aoff_lvl_q) begin
      state_d = FPSS_AUTO_OFF;
      cyc_d   = CNT_ZERO;
      seen_d  = 1'b0;
    end else begin
      case (state_q)
        FPSS_SHUTDOWN, FPSS_AUTO_OFF: begin
          state_d = FPSS_START1;
          cyc_d   = CNT_ZERO;
          seen_d  = 1'b0;
        end
        FPSS_START1, FPSS_START2: begin
          if (tick_ev) begin
            cyc_d = cyc_q + CNT_ONE;
            if (cnt_hit(cyc_q, STARTUP_CYCLES)) begin
              cyc_d  = CNT_ZERO;
              seen_d = 1'b0;
              if (seen_q || pulse_ev || !SENSE_EN) begin
                state_d = FPSS_RUN;
              end else if (state_q == FPSS_START1) begin
                state_d = FPSS_START2;
              end else begin
                state_d = FPSS_FAULT;
                pcnt_d  = CNT_ZERO;
              end
            end
          end
        end
        FPSS_RUN: begin
          if (pulse_ev) begin
            cyc_d  = CNT_ZERO;
            seen_d = 1'b0;
          end else if (tick_ev) begin
            cyc_d = cyc_q + CNT_ONE;
            if (cnt_hit(cyc_q, MISSING_CYCLES)) begin
              state_d = FPSS_DIAG;
              cyc_d   = CNT_ZERO;
              seen_d  = 1'b0;
            end
          end
        end
        FPSS_DIAG: begin
          if (pulse_ev || seen_q) begin
            state_d = FPSS_RUN;
            cyc_d   = CNT_ZERO;
            seen_d  = 1'b0;
          end else if (tick_ev) begin
            cyc_d = cyc_q + CNT_ONE;
            if (cnt_hit(cyc_q, DIAG_CYCLES)) begin
              state_d = FPSS_START2;
              cyc_d   = CNT_ZERO;
            end
          end
        end
        FPSS_FAULT: begin
          if (pulse_ev) begin
            pcnt_d = pcnt_q + CNT_ONE;
          end
          if (pulse_ev && (pcnt_q == CNT_W'(RECOVER_PULSES - 1))) begin
            state_d = FPSS_RUN;
            cyc_d   = CNT_ZERO;
            seen_d  = 1'b0;
          end else if (tick_ev) begin
            cyc_d = cyc_q + CNT_ONE;
            if (cnt_hit(cyc_q, RECOVER_WINDOW)) begin
              cyc_d  = CNT_ZERO;
              pcnt_d = pulse_ev ? CNT_ONE : CNT_ZERO;
            end
          end
        end
        default: begin
          state_d = FPSS_SHUTDOWN;
          cyc_d   = CNT_ZERO;
        end
      endcase
    end
    // Output values follow the next state so they line up with it.
    case (state_d)
      FPSS_SHUTDOWN, FPSS_AUTO_OFF: drive_d = 1'b0;
      FPSS_RUN:                     drive_d = duty_lvl_d;
      FPSS_FAULT:                   drive_d = 1'b1;
      default:                      drive_d = 1'b1;
    endcase
    flag_d = (state_d == FPSS_FAULT) ||
             (OVERTEMP_EN && otmp_lvl_d && (state_d != FPSS_SHUTDOWN) && (state_d != FPSS_AUTO_OFF));
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state_q <= FPSS_SHUTDOWN;
      cyc_q   <= CNT_ZERO;
      pcnt_q  <= CNT_ZERO;
      seen_q  <= 1'b0;
      drive_q <= 1'b0;
      flag_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q   <= cyc_d;
      pcnt_q  <= pcnt_d;
      seen_q  <= seen_d;
      drive_q <= drive_d;
      flag_q  <= flag_d;
    end
  end

  assign fan_drive_out          = drive_q;
  assign overtemp_flag_n_out    = 1'b0;
  assign overtemp_flag_n_oe_out = flag_q;

endmodule : fpss_core
`default_nettype wire

// ==== fpss_pkg.sv ====
package fpss_pkg;

  // Cycle counts in whole PWM periods, except RECOVER_PULSES, which counts fan pulses, and CNT_W, the counter width in bits.
  localparam int STARTUP_CYCLES  = 32;
  localparam int MISSING_CYCLES  = 32;
  localparam int DIAG_CYCLES     = 3;
  localparam int RECOVER_WINDOW  = 32;
  localparam int RECOVER_PULSES  = 16;
  localparam int CNT_W           = 6;

  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

  typedef enum logic [2:0] {
    FPSS_SHUTDOWN,
    FPSS_AUTO_OFF,
    FPSS_START1,
    FPSS_START2,
    FPSS_RUN,
    FPSS_DIAG,
    FPSS_FAULT
  } fpss_state_t;

  // Comparator results delivered by the analog front end.
  typedef struct packed {
    logic duty_hi;
    logic shutdown;
    logic auto_off;
    logic overtemp;
  } fpss_cmp_t;

endpackage : fpss_pkg

// ==== fpss_core_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpss_chk
  import fpss_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic      sys_clk_in,
  input wire logic      nrst_in,
  input wire fpss_cmp_t cmp_in,
  input wire logic      ramp_tick_in,
  input wire logic      fan_pulse_in,
  // Outputs.
  input wire logic      fan_drive_out,
  input wire logic      overtemp_flag_n_out,
  input wire logic      overtemp_flag_n_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_od; overtemp_flag_n_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("flag data not low");
  property p_shut; cmp_in.shutdown [*6] |-> !fan_drive_out && !overtemp_flag_n_oe_out; endproperty
  a_shut: assert property (p_shut) else $error("shutdown not honoured");
  property p_auto; cmp_in.auto_off [*6] |-> !fan_drive_out && !overtemp_flag_n_oe_out; endproperty
  a_auto: assert property (p_auto) else $error("auto off not honoured");
  property p_ot; (cmp_in.overtemp && !cmp_in.shutdown && !cmp_in.auto_off) [*6] |-> overtemp_flag_n_oe_out; endproperty
  a_ot: assert property (p_ot) else $error("overtemp flag missing");
  property p_hold; (overtemp_flag_n_oe_out && !cmp_in.overtemp) [*8] |-> fan_drive_out; endproperty
  a_hold: assert property (p_hold) else $error("drive low in fault");
  property p_fall;
    $fell(fan_drive_out) |-> !$past(cmp_in.duty_hi, 3) || $past(cmp_in.shutdown, 3) || $past(cmp_in.auto_off, 3);
  endproperty
  a_fall: assert property (p_fall) else $error("drive fell without cause");
  property p_rel; $fell(cmp_in.shutdown) && !cmp_in.auto_off |-> ##[3:6] fan_drive_out; endproperty
  a_rel: assert property (p_rel) else $error("no start after shutdown");
  property p_arel; $fell(cmp_in.auto_off) && !cmp_in.shutdown |-> ##6 fan_drive_out [*8]; endproperty
  a_arel: assert property (p_arel) else $error("no start after auto off");
endmodule : fpss_chk
bind fpss_core fpss_chk fpss_chk_i (.sys_clk_in, .nrst_in, .cmp_in, .ramp_tick_in, .fan_pulse_in, .fan_drive_out,
  .overtemp_flag_n_out, .overtemp_flag_n_oe_out);
`default_nettype wire

// ==== fpss_fan.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpss_fan (
  // Clock, drive and stall control.
  input  wire logic sys_clk_in,
  input  wire logic drive_in,
  input  wire logic spin_in,
  // Sense pulse.
  output logic      pulse_out
);
  logic       turn_q = 1'b0;
  logic [2:0] ph_q   = 3'h0;
  always_ff @(posedge sys_clk_in) begin
    turn_q <= spin_in && (turn_q || drive_in);
    ph_q   <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
  end
  assign pulse_out = turn_q && (ph_q < 3'h3);
endmodule : fpss_fan
`default_nettype wire

// ==== tb_fan_pwm_startup_fault_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_fan_pwm_startup_fault_sequencer;
  import fpss_pkg::*;
  logic       sys_clk_in   = 1'b0;
  logic       nrst_in      = 1'b0;
  fpss_cmp_t  cmp_in       = '0;
  logic       ramp_tick_in = 1'b0;
  logic       spin         = 1'b1;
  logic [1:0] tk_q         = 2'h0;
  logic       fan_pulse_in;
  logic       fan_drive_out;
  logic       flag_n;
  logic       flag_oe;
  wire        flag_pin     = flag_oe ? flag_n : 1'b1;
  int         err_count    = 0;
  int         checks       = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    tk_q <= tk_q + 2'h1;
    if (tk_q == 2'h3) begin
      ramp_tick_in <= ~ramp_tick_in;
    end
  end
  fpss_core fpss_core_i (.sys_clk_in, .nrst_in, .cmp_in, .ramp_tick_in, .fan_pulse_in, .fan_drive_out,
    .overtemp_flag_n_out(flag_n), .overtemp_flag_n_oe_out(flag_oe));
  fpss_fan fpss_fan_i (.sys_clk_in, .drive_in(fan_drive_out), .spin_in(spin), .pulse_out(fan_pulse_in));
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : wt
  // Waits for the drive (s=0) or the flag being asserted (s=1) to reach v.
  task automatic wv(input bit s, input logic v, input int n);
    while (n > 0 && (s ? !flag_pin : fan_drive_out) !== v) begin
      wt(1);
      n--;
    end
    if ((s ? !flag_pin : fan_drive_out) !== v) begin
      err_count++;
      report_and_stop();
    end
  endtask : wv
  task automatic t_start;
    wt(160);
    chk(fan_drive_out, 1'b1);
    wv(0, 1'b0, 200);
    chk(flag_pin, 1'b1);
    @(posedge sys_clk_in) cmp_in.duty_hi <= 1'b1;
    wt(8);
    chk(fan_drive_out, 1'b1);
    @(posedge sys_clk_in) cmp_in.duty_hi <= 1'b0;
    wt(8);
    chk(fan_drive_out, 1'b0);
  endtask : t_start
  task automatic t_stall;
    @(posedge sys_clk_in) spin <= 1'b0;
    wt(200);
    chk(fan_drive_out, 1'b0);
    wv(0, 1'b1, 150);
    @(posedge sys_clk_in) spin <= 1'b1;
    wv(0, 1'b0, 60);
    chk(flag_pin, 1'b1);
  endtask : t_stall
  task automatic t_ot;
    @(posedge sys_clk_in) cmp_in.overtemp <= 1'b1;
    wt(8);
    chk(flag_pin, 1'b0);
    @(posedge sys_clk_in) cmp_in.overtemp <= 1'b0;
    wt(8);
    chk(flag_pin, 1'b1);
  endtask : t_ot
  task automatic t_off;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_in);
      cmp_in.shutdown <= (i == 0);
      cmp_in.auto_off <= (i == 1);
      cmp_in.overtemp <= 1'b1;
      wt(8);
      chk(fan_drive_out, 1'b0);
      chk(flag_pin, 1'b1);
      @(posedge sys_clk_in) cmp_in <= '0;
      wt(8);
      chk(fan_drive_out, 1'b1);
      wv(0, 1'b0, 400);
    end
  endtask : t_off
  task automatic t_fault;
    @(posedge sys_clk_in);
    nrst_in <= 1'b0;
    spin    <= 1'b0;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in) nrst_in <= 1'b1;
    wt(400);
    chk(fan_drive_out, 1'b1);
    chk(flag_pin, 1'b1);
    wv(1, 1'b1, 300);
    wt(300);
    chk(fan_drive_out, 1'b1);
    chk(flag_pin, 1'b0);
    @(posedge sys_clk_in) spin <= 1'b1;
    wv(1, 1'b0, 600);
    wt(8);
    chk(fan_drive_out, 1'b0);
  endtask : t_fault
  initial begin
    wt(2);
    @(posedge sys_clk_in) nrst_in <= 1'b1;
    t_start();
    t_stall();
    t_ot();
    t_off();
    t_fault();
    report_and_stop();
  end
endmodule : tb_fan_pwm_startup_fault_sequencer
`default_nettype wire
